// ### common/wdt_pkg.sv
/*
 Constants, types and bundles shared by the window watchdog and reset supervisor.
 Assumes the system clock runs at 50 MHz and comparator results arrive as logic levels.
*/
package wdt_pkg;
	// System clock
	localparam int unsigned CLK_PERIOD_NS           = 32'h0000_0014; // 20 ns
	localparam int unsigned NS_PER_MS               = 32'h000F_4240;
	// Watchdog oscillator period, independent of switching clock
	localparam int unsigned WD_TICK_NS              = 32'h0001_86A0; // 100 us
	localparam int unsigned WD_TICK_CYCLES          = WD_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned WD_TICKS_PER_MS         = NS_PER_MS / WD_TICK_NS;
	// Enable delay before soft-start
	localparam int unsigned ENABLE_DELAY_MS         = 32'h0000_0010; // 16 ms
	localparam int unsigned ENABLE_DELAY_CYCLES     = ENABLE_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;
	// First-kick timeout: 2.87 ms per pF plus 20 ms
	localparam int unsigned FIRST_KICK_SLOPE_X100   = 32'h0000_011F; // 287
	localparam int unsigned SCALE_100               = 32'h0000_0064; // 100
	localparam int unsigned FIRST_KICK_OFFSET_MS    = 32'h0000_0014; // 20
	// Window lengths as fractions of the first-kick timeout
	localparam int unsigned CLOSED_SHIFT            = 32'h0000_0006;
	localparam int unsigned OPEN_SHIFT              = 32'h0000_0004;
	// Reset release delay: 2475 / current in uA, in ms
	localparam int unsigned RST_DELAY_NUM_MS        = 32'h0000_09AB; // 2475
	localparam int unsigned RST_DELAY_LINEAR_MAX_UA = 32'h0000_01F4; // 500
	localparam int unsigned RST_NO_DELAY_UA         = 32'h0000_03E8; // 1000
	// Extra low time after a watchdog fault
	localparam int unsigned WD_FAULT_EXTRA_TICKS    = 32'h0000_0003;
	// Widths
	localparam int unsigned CAP_W                   = 32'h0000_000A;
	localparam int unsigned CUR_W                   = 32'h0000_000A;
	localparam int unsigned TICK_W                  = 32'h0000_0010;
	// Reset output indices
	localparam int unsigned RST_PRIMARY             = 32'h0000_0000;
	localparam int unsigned RST_SECONDARY           = 32'h0000_0001;
	localparam int unsigned RST_EXTERNAL            = 32'h0000_0002;
	localparam int unsigned RST_NUM                 = 32'h0000_0003;

	typedef enum logic [1:0] {
		WD_IDLE   = 2'b00,
		WD_FIRST  = 2'b01,
		WD_CLOSED = 2'b10,
		WD_OPEN   = 2'b11
	} wd_state_t;

	typedef enum logic [2:0] {
		CAUSE_NONE          = 3'b000,
		CAUSE_FIRST_TIMEOUT = 3'b001,
		CAUSE_CLOSED_KICK   = 3'b010,
		CAUSE_OPEN_TIMEOUT  = 3'b011,
		CAUSE_KICK_STUCK    = 3'b100
	} wd_cause_t;

	typedef struct packed {
		logic primary_in_window;
		logic primary_above_2v;
		logic secondary_in_window;
		logic ext_monitor_in_window;
		logic enable;
		logic thermal_shutdown_fault;
		logic battery_fault;
	} supply_status_t;

	typedef struct packed {
		logic [CUR_W-1:0] primary_ua;
		logic [CUR_W-1:0] secondary_ua;
		logic [CUR_W-1:0] external_ua;
	} reset_delay_set_t;
endpackage

// ### hw/wd_osc_tick.sv
/*
 Watchdog oscillator: a free-running divider giving one tick pulse per period.
 Assumes nothing else shares this divider, so it stays independent of switching timing.
*/
`timescale 1ns/100ps
module wd_osc_tick #(
	parameter int unsigned DIV = wdt_pkg::WD_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Tick
	output logic      tick_o
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] count;

	generate
		if (DIV < 2) begin : g_bad_div
			$error("wd_osc_tick: DIV must be at least 2");
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			count <= '0;
		end else if (count == CW'(DIV - 1)) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= (count == CW'(DIV - 1));
		end
	end
endmodule

// ### hw/window_watchdog_reset_supervisor.sv
/*
 Window watchdog and reset-output supervisor for a two-output regulator.
 Assumes all inputs are synchronous to ref_clk_i and comparator levels are already digital.
*/
`timescale 1ns/100ps
module window_watchdog_reset_supervisor #(
	parameter int unsigned WD_TICK_CYCLES      = wdt_pkg::WD_TICK_CYCLES,
	parameter int unsigned ENABLE_DELAY_CYCLES = wdt_pkg::ENABLE_DELAY_CYCLES
) (
	// Clock and reset
	input  wire logic                            ref_clk_i,
	input  wire logic                            rst_i,
	// Supply comparators and global faults
	input  wire wdt_pkg::supply_status_t         supply_status_i,
	// Watchdog pins
	input  wire logic                            wd_kick_in_i,
	input  wire logic                            wd_timing_cap_low_i,
	input  wire logic                            ext_freq_sync_high_i,
	// Part option and analog settings
	input  wire logic                            shutdown_on_fault_i,
	input  wire logic [wdt_pkg::CAP_W-1:0]       wd_timing_capacitor_pf_i,
	input  wire wdt_pkg::reset_delay_set_t       reset_delay_ua_i,
	// Reset outputs, active low
	output logic                                 primary_fault_reset_n_o,
	output logic                                 secondary_fault_reset_n_o,
	output logic                                 external_supply_reset_n_o,
	// Regulator control and status
	output logic                                 regulators_enable_o,
	output logic                                 wd_fault_o,
	output wdt_pkg::wd_cause_t                   wd_fault_cause_o,
	output logic                                 debug_mode_o
);
	localparam int unsigned TW  = wdt_pkg::TICK_W;
	localparam int unsigned EW  = $clog2(ENABLE_DELAY_CYCLES + 1);
	localparam int unsigned NUM = wdt_pkg::RST_NUM;

	generate
		if (WD_TICK_CYCLES < 2) begin : g_bad_tick
			$error("WD_TICK_CYCLES must be at least 2");
		end
		if (ENABLE_DELAY_CYCLES < 1) begin : g_bad_en
			$error("ENABLE_DELAY_CYCLES must be at least 1");
		end
	endgenerate

	function automatic logic [TW-1:0] first_kick_ticks(input logic [wdt_pkg::CAP_W-1:0] pf);
		int unsigned t;
		t = wdt_pkg::FIRST_KICK_SLOPE_X100 * int'(pf) * wdt_pkg::WD_TICKS_PER_MS;
		t = t / wdt_pkg::SCALE_100;
		t = t + wdt_pkg::FIRST_KICK_OFFSET_MS * wdt_pkg::WD_TICKS_PER_MS;
		return t[TW-1:0];
	endfunction

	// Currents between the linear limit and 1 mA keep the formula
	function automatic logic [TW-1:0] release_ticks(input logic [wdt_pkg::CUR_W-1:0] ua);
		int unsigned t;
		t = wdt_pkg::RST_DELAY_NUM_MS * wdt_pkg::WD_TICKS_PER_MS;
		if (int'(ua) >= wdt_pkg::RST_NO_DELAY_UA) begin
			t = 0;
		end else if (ua != '0) begin
			t = t / int'(ua);
		end
		return t[TW-1:0];
	endfunction

	logic                wd_tick;
	wdt_pkg::wd_state_t  state;
	wdt_pkg::wd_state_t  next_state;
	wdt_pkg::wd_cause_t  next_cause;
	logic                next_fault;
	logic                load_first;
	logic                load_window;
	logic [TW-1:0]       timeout_ticks;
	logic [TW-1:0]       closed_ticks;
	logic [TW-1:0]       open_ticks;
	logic [TW-1:0]       period_cnt;
	logic [TW-1:0]       closed_cnt;
	logic                period_expire;
	logic                closed_done;
	logic                kick_q;
	logic                kick_rise;
	logic                kick_stuck;
	logic                prim_q;
	logic                prim_rise;
	logic                debug_mode;
	logic                cap_fault;
	logic [1:0]          hold_cnt;
	logic                shutdown_hold;
	logic [EW-1:0]       reg_off_cnt;
	logic [NUM-1:0]      rst_cond;
	logic                rst_n [NUM];
	logic [TW-1:0]       rst_cnt [NUM];
	logic [TW-1:0]       rst_delay [NUM];
	wdt_pkg::supply_status_t st;

	assign st = supply_status_i;

	wd_osc_tick #(
		.DIV    (WD_TICK_CYCLES)
	) u_wd_osc (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.tick_o    (wd_tick)
	);

	// Interval lengths in oscillator ticks
	assign timeout_ticks = first_kick_ticks(wd_timing_capacitor_pf_i);
	assign closed_ticks  = timeout_ticks >> wdt_pkg::CLOSED_SHIFT;
	assign open_ticks    = timeout_ticks >> wdt_pkg::OPEN_SHIFT;

	assign rst_delay[wdt_pkg::RST_PRIMARY]   = release_ticks(reset_delay_ua_i.primary_ua);
	assign rst_delay[wdt_pkg::RST_SECONDARY] = release_ticks(reset_delay_ua_i.secondary_ua);
	assign rst_delay[wdt_pkg::RST_EXTERNAL]  = release_ticks(reset_delay_ua_i.external_ua);

	assign debug_mode    = wd_timing_cap_low_i & ext_freq_sync_high_i;
	assign cap_fault     = wd_timing_cap_low_i & ~ext_freq_sync_high_i;
	assign kick_rise     = wd_kick_in_i & ~kick_q;
	assign prim_rise     = rst_n[wdt_pkg::RST_PRIMARY] & ~prim_q;
	assign period_expire = wd_tick && (period_cnt <= TW'(1));
	assign closed_done   = wd_tick && (closed_cnt <= TW'(1));

	// Edge detectors
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			kick_q <= 1'b0;
			prim_q <= 1'b0;
		end else begin
			kick_q <= wd_kick_in_i;
			prim_q <= rst_n[wdt_pkg::RST_PRIMARY];
		end
	end

	// Watchdog sequencing
	always_comb begin
		next_state  = state;
		next_fault  = 1'b0;
		next_cause  = wdt_pkg::CAUSE_NONE;
		load_first  = 1'b0;
		load_window = 1'b0;
		unique case (state)
			wdt_pkg::WD_IDLE: begin
				if (prim_rise && wd_kick_in_i) begin
					next_state  = wdt_pkg::WD_CLOSED;
					load_window = 1'b1;
				end else if (prim_rise) begin
					next_state = wdt_pkg::WD_FIRST;
					load_first = 1'b1;
				end
			end
			wdt_pkg::WD_FIRST: begin
				if (kick_rise) begin
					next_state  = wdt_pkg::WD_CLOSED;
					load_window = 1'b1;
				end else if (period_expire) begin
					next_state = wdt_pkg::WD_IDLE;
					next_fault = 1'b1;
					next_cause = kick_stuck ? wdt_pkg::CAUSE_KICK_STUCK :
						wdt_pkg::CAUSE_FIRST_TIMEOUT;
				end
			end
			wdt_pkg::WD_CLOSED: begin
				if (kick_rise) begin
					next_state = wdt_pkg::WD_IDLE;
					next_fault = 1'b1;
					next_cause = wdt_pkg::CAUSE_CLOSED_KICK;
				end else if (closed_done) begin
					next_state = wdt_pkg::WD_OPEN;
				end
			end
			wdt_pkg::WD_OPEN: begin
				if (kick_rise) begin
					next_state  = wdt_pkg::WD_CLOSED;
					load_window = 1'b1;
				end else if (period_expire) begin
					next_state = wdt_pkg::WD_IDLE;
					next_fault = 1'b1;
					next_cause = kick_stuck ? wdt_pkg::CAUSE_KICK_STUCK :
						wdt_pkg::CAUSE_OPEN_TIMEOUT;
				end
			end
		endcase
		// Reset low or debug parks the watchdog without a fault
		if (!rst_n[wdt_pkg::RST_PRIMARY] || debug_mode) begin
			next_state  = wdt_pkg::WD_IDLE;
			next_fault  = 1'b0;
			next_cause  = wdt_pkg::CAUSE_NONE;
			load_first  = 1'b0;
			load_window = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= wdt_pkg::WD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Period and closed-window counters
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			period_cnt <= '0;
			closed_cnt <= '0;
		end else if (load_first) begin
			period_cnt <= timeout_ticks;
			closed_cnt <= '0;
		end else if (load_window) begin
			period_cnt <= open_ticks;
			closed_cnt <= closed_ticks;
		end else if (wd_tick) begin
			if (period_cnt != '0) begin
				period_cnt <= period_cnt - 1'b1;
			end
			if (closed_cnt != '0) begin
				closed_cnt <= closed_cnt - 1'b1;
			end
		end
	end

	// Kick level held since the current period began
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			kick_stuck <= 1'b0;
		end else if (load_first || load_window) begin
			kick_stuck <= wd_kick_in_i;
		end else if (!wd_kick_in_i) begin
			kick_stuck <= 1'b0;
		end
	end

	// Fault reporting
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wd_fault_o       <= 1'b0;
			wd_fault_cause_o <= wdt_pkg::CAUSE_NONE;
		end else begin
			wd_fault_o <= next_fault;
			if (next_fault) begin
				wd_fault_cause_o <= next_cause;
			end
		end
	end

	// Extra oscillator cycles before the normal release delay starts
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			hold_cnt <= '0;
		end else if (next_fault) begin
			hold_cnt <= 2'(wdt_pkg::WD_FAULT_EXTRA_TICKS);
		end else if (wd_tick && hold_cnt != '0) begin
			hold_cnt <= hold_cnt - 1'b1;
		end
	end

	// Shutdown option keeps reset low until the enable delay has run out
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			shutdown_hold <= 1'b0;
		end else if (next_fault && shutdown_on_fault_i) begin
			shutdown_hold <= 1'b1;
		end else if (reg_off_cnt == '0) begin
			shutdown_hold <= 1'b0;
		end
	end

	// Switching inhibit after enable or a shutdown fault
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_off_cnt <= EW'(ENABLE_DELAY_CYCLES);
		end else if (!st.enable) begin
			reg_off_cnt <= EW'(ENABLE_DELAY_CYCLES);
		end else if (next_fault && shutdown_on_fault_i) begin
			reg_off_cnt <= EW'(ENABLE_DELAY_CYCLES);
		end else if (reg_off_cnt != '0) begin
			reg_off_cnt <= reg_off_cnt - 1'b1;
		end
	end

	// Keep-running option never touches this enable
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			regulators_enable_o <= 1'b0;
		end else begin
			regulators_enable_o <= st.enable && (reg_off_cnt == '0) &&
				!(next_fault && shutdown_on_fault_i);
		end
	end

	// Reset conditions per output
	always_comb begin
		rst_cond[wdt_pkg::RST_PRIMARY] = !st.primary_in_window || cap_fault ||
			shutdown_hold || (hold_cnt != '0) || next_fault ||
			(st.primary_above_2v && (!st.enable || st.thermal_shutdown_fault ||
			st.battery_fault));
		rst_cond[wdt_pkg::RST_SECONDARY] = !st.secondary_in_window ||
			st.battery_fault || st.thermal_shutdown_fault;
		rst_cond[wdt_pkg::RST_EXTERNAL] = !st.ext_monitor_in_window;
	end

	// Release delay counters, counted on the watchdog oscillator
	for (genvar i = 0; i < NUM; i++) begin : g_rst
		always_ff @(posedge ref_clk_i) begin
			if (rst_i) begin
				rst_cnt[i] <= '0;
				rst_n[i]   <= 1'b0;
			end else if (rst_cond[i]) begin
				rst_cnt[i] <= rst_delay[i];
				rst_n[i]   <= 1'b0;
			end else if (rst_cnt[i] == '0) begin
				rst_n[i] <= 1'b1;
			end else if (wd_tick) begin
				rst_cnt[i] <= rst_cnt[i] - 1'b1;
			end
		end
	end

	// Registered pin copies
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			primary_fault_reset_n_o   <= 1'b0;
			secondary_fault_reset_n_o <= 1'b0;
			external_supply_reset_n_o <= 1'b0;
			debug_mode_o              <= 1'b0;
		end else begin
			primary_fault_reset_n_o   <= rst_n[wdt_pkg::RST_PRIMARY];
			secondary_fault_reset_n_o <= rst_n[wdt_pkg::RST_SECONDARY];
			external_supply_reset_n_o <= rst_n[wdt_pkg::RST_EXTERNAL];
			debug_mode_o              <= debug_mode;
		end
	end
endmodule

// ### testbench/wd_sup_chk.sv
/*
 Checker bound to the window watchdog and reset supervisor top.
 Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/100ps
module wd_sup_chk #(
	parameter int unsigned WD_TICK_CYCLES      = 4,
	parameter int unsigned ENABLE_DELAY_CYCLES = 20
) (
	// Clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_i,
	// Watched inputs
	input  wire wdt_pkg::supply_status_t supply_status_i,
	input  wire logic                    wd_timing_cap_low_i,
	input  wire logic                    ext_freq_sync_high_i,
	input  wire logic                    shutdown_on_fault_i,
	// Watched outputs
	input  wire logic                    primary_fault_reset_n_o,
	input  wire logic                    secondary_fault_reset_n_o,
	input  wire logic                    external_supply_reset_n_o,
	input  wire logic                    regulators_enable_o,
	input  wire logic                    wd_fault_o,
	input  wire logic                    debug_mode_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Edges the enable input has stayed high
	logic [31:0] en_high_cycles;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !supply_status_i.enable) begin
			en_high_cycles <= 32'h0000_0000;
		end else begin
			en_high_cycles <= en_high_cycles + 32'h0000_0001;
		end
	end
	sequence primary_held_low;
		(!primary_fault_reset_n_o)[*8];
	endsequence
	sequence regs_held_off;
		(!regulators_enable_o)[*8];
	endsequence
	chk_primary_window: assert property (
		!supply_status_i.primary_in_window |-> ##2 !primary_fault_reset_n_o)
		else $error("primary reset missed window fault");
	chk_global_faults: assert property (
		supply_status_i.primary_above_2v && (!supply_status_i.enable
		|| supply_status_i.thermal_shutdown_fault || supply_status_i.battery_fault)
		|-> ##2 !primary_fault_reset_n_o) else $error("primary reset missed global fault");
	chk_secondary_window: assert property (
		(!supply_status_i.secondary_in_window || supply_status_i.thermal_shutdown_fault
		|| supply_status_i.battery_fault) |-> ##2 !secondary_fault_reset_n_o)
		else $error("secondary reset missed fault");
	chk_external_window: assert property (
		!supply_status_i.ext_monitor_in_window |-> ##2 !external_supply_reset_n_o)
		else $error("external reset missed window fault");
	chk_fault_hold: assert property (
		wd_fault_o |=> primary_held_low) else $error("primary reset hold too short");
	chk_keep_running: assert property (
		wd_fault_o && !shutdown_on_fault_i && regulators_enable_o |=> regulators_enable_o)
		else $error("regulators stopped on keep-running fault");
	chk_shutdown_off: assert property (
		wd_fault_o && shutdown_on_fault_i |-> ##1 regs_held_off)
		else $error("regulators not shut down on fault");
	chk_debug_quiet: assert property (
		debug_mode_o && $past(debug_mode_o) |-> !wd_fault_o)
		else $error("watchdog fault in debug mode");
	chk_cap_fault: assert property (
		wd_timing_cap_low_i && !ext_freq_sync_high_i |-> ##[1:2] !primary_fault_reset_n_o)
		else $error("timing pin fault not reported");
	chk_enable_delay: assert property (
		$rose(regulators_enable_o) |-> en_high_cycles >= ENABLE_DELAY_CYCLES)
		else $error("switching started before enable delay");
	chk_idle_in_reset: assert property (
		(!supply_status_i.primary_in_window)[*3] |-> !wd_fault_o)
		else $error("watchdog fault while primary out of regulation");
endmodule

bind window_watchdog_reset_supervisor wd_sup_chk #(
	.WD_TICK_CYCLES(WD_TICK_CYCLES), .ENABLE_DELAY_CYCLES(ENABLE_DELAY_CYCLES)
) u_chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .supply_status_i(supply_status_i),
	.wd_timing_cap_low_i(wd_timing_cap_low_i), .ext_freq_sync_high_i(ext_freq_sync_high_i),
	.shutdown_on_fault_i(shutdown_on_fault_i),
	.primary_fault_reset_n_o(primary_fault_reset_n_o),
	.secondary_fault_reset_n_o(secondary_fault_reset_n_o),
	.external_supply_reset_n_o(external_supply_reset_n_o),
	.regulators_enable_o(regulators_enable_o), .wd_fault_o(wd_fault_o),
	.debug_mode_o(debug_mode_o)
);

// ### testbench/host_kick_model.sv
/*
 Host model toggling the watchdog kick input with a set period.
 Assumes the bench starts and stops it; when stopped it holds the commanded level.
*/
`timescale 1ns/100ps
module host_kick_model (
	// Clock
	input  wire logic        ref_clk_i,
	// Bench control
	input  wire logic        run_i,
	input  wire logic        hold_high_i,
	input  wire logic [15:0] period_i,
	// Kick to the device
	output logic             kick_o
);
	logic [15:0] phase;
	// Nonblocking on the edge, so the device sees the old level
	always @(posedge ref_clk_i) begin
		if (!run_i) begin
			phase  <= 16'h0000;
			kick_o <= hold_high_i;
		end else begin
			phase  <= (phase == period_i - 16'h0001) ? 16'h0000 : phase + 16'h0001;
			kick_o <= (phase < (period_i >> 1));
		end
	end
endmodule

// ### testbench/tb_top.sv
/*
 Self-checking bench for the window watchdog and reset supervisor.
 Assumes shortened tick and enable delay so every watchdog interval fits a short run.
*/
`timescale 1ns/100ps
module tb_top;
	localparam int TICK  = 4;
	localparam int ENDLY = 20;
	// Zero timing cap leaves only the fixed offset
	localparam int TO_CYC = wdt_pkg::FIRST_KICK_OFFSET_MS * wdt_pkg::WD_TICKS_PER_MS * TICK;
	localparam int OP_CYC = TO_CYC / 16;
	localparam int DLY_CYC = wdt_pkg::RST_DELAY_NUM_MS * wdt_pkg::WD_TICKS_PER_MS / 990 * TICK;
	// Ten pF timing cap gives 48.7 ms
	localparam int T2_CYC = (wdt_pkg::FIRST_KICK_SLOPE_X100 * 10 * wdt_pkg::WD_TICKS_PER_MS /
		wdt_pkg::SCALE_100 + wdt_pkg::FIRST_KICK_OFFSET_MS * wdt_pkg::WD_TICKS_PER_MS) * TICK;
	localparam logic [6:0] GOOD = 7'h7C;
	localparam logic [6:0] MASKS [6] = '{7'h40, 7'h10, 7'h08, 7'h02, 7'h01, 7'h04};
	localparam logic [2:0] EXPV [6]  = '{3'h3, 3'h5, 3'h6, 3'h1, 3'h1, 3'h3};
	logic                    ref_clk_i;
	logic                    rst_i;
	wdt_pkg::supply_status_t stat;
	logic                    cap_low, sync_high, shutdown, run, hold_high, kick;
	logic [15:0]             period;
	logic [9:0]              ua_pri;
	logic [9:0]              cap_pf;
	logic                    prim_n, sec_n, ext_n, regs_en, wd_fault, debug;
	wdt_pkg::wd_cause_t      cause;
	int                      mismatches, total_checks, fault_cnt, n, f0, i;

	window_watchdog_reset_supervisor #(.WD_TICK_CYCLES(TICK), .ENABLE_DELAY_CYCLES(ENDLY)) u_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .supply_status_i(stat), .wd_kick_in_i(kick),
		.wd_timing_cap_low_i(cap_low), .ext_freq_sync_high_i(sync_high),
		.shutdown_on_fault_i(shutdown), .wd_timing_capacitor_pf_i(cap_pf),
		.reset_delay_ua_i({ua_pri, 10'h3E8, 10'h3E8}), .primary_fault_reset_n_o(prim_n),
		.secondary_fault_reset_n_o(sec_n), .external_supply_reset_n_o(ext_n),
		.regulators_enable_o(regs_en), .wd_fault_o(wd_fault), .wd_fault_cause_o(cause),
		.debug_mode_o(debug));
	host_kick_model u_host (.ref_clk_i(ref_clk_i), .run_i(run), .hold_high_i(hold_high),
		.period_i(period), .kick_o(kick));

	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) if (wd_fault === 1'b1) fault_cnt++;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge ref_clk_i);
	endtask
	// Bounded wait for primary reset (0) or regulators (1) to go high
	task wait_high(input int sel, input int hi);
		n = 0;
		while ((sel ? regs_en : prim_n) !== 1'b1) begin
			cyc(1);
			n++;
			if (n > hi) begin
				mismatches++;
				finish_test;
			end
		end
	endtask
	task wait_fault(input int lo, input int hi, input logic [2:0] exp_cause);
		n = 0;
		while (wd_fault !== 1'b1) begin
			cyc(1);
			n++;
			if (n > hi) begin
				mismatches++;
				finish_test;
			end
		end
		check(n >= lo, 1);
		cyc(1);
		check(cause, exp_cause);
	endtask

	initial begin
		stat = GOOD;
		{cap_low, sync_high, shutdown, run, hold_high} = 5'h00;
		period = 16'h001E;
		ua_pri = 10'h3E8;
		cap_pf = 10'h000;
		{mismatches, total_checks, fault_cnt} = 0;
		rst_i = 1'b1;
		cyc(4);
		rst_i = 1'b0;
		check({prim_n, sec_n, ext_n, regs_en}, 0);
		cyc(ENDLY - 4);
		check(regs_en, 0);
		cyc(8);
		check(regs_en, 1);
		wait_high(0, 50);
		for (i = 0; i < 6; i++) begin
			stat = wdt_pkg::supply_status_t'(GOOD ^ MASKS[i]);
			cyc(3);
			check({prim_n, sec_n, ext_n}, EXPV[i]);
			stat = GOOD;
			cyc(ENDLY + 4);
			wait_high(0, 50);
		end
		// No kick at all; timer began when primary rose in the last loop pass
		wait_fault(TO_CYC - ENDLY - 3 * TICK, TO_CYC + 3 * TICK, 3'h1);
		check(regs_en, 1);
		wait_high(0, 30);
		check(n >= 2 * TICK && n <= 5 * TICK, 1);
		// Well-timed kicks, then the host goes quiet
		f0 = fault_cnt;
		run = 1'b1;
		cyc(300);
		check(fault_cnt, f0);
		run = 1'b0;
		wait_fault(0, OP_CYC + 3 * TICK, 3'h3);
		wait_high(0, 30);
		// Second kick inside the closed window
		period = 16'h0006;
		run = 1'b1;
		wait_fault(4, 24, 3'h2);
		run = 1'b0;
		hold_high = 1'b1;
		wait_high(0, 30);
		wait_fault(OP_CYC - 2 * TICK, OP_CYC + 3 * TICK, 3'h4);
		hold_high = 1'b0;
		wait_high(0, 30);
		// Watchdog idle while primary is out of regulation; slow release
		ua_pri = 10'h3DE;
		f0 = fault_cnt;
		stat = wdt_pkg::supply_status_t'(GOOD ^ 7'h40);
		cyc(TO_CYC + 100);
		check(fault_cnt, f0);
		stat = GOOD;
		wait_high(0, DLY_CYC + 30);
		check(n >= DLY_CYC - TICK && n <= DLY_CYC + 3 * TICK, 1);
		ua_pri = 10'h3E8;
		// Shutdown option
		shutdown = 1'b1;
		run = 1'b1;
		wait_fault(4, 24, 3'h2);
		run = 1'b0;
		check(regs_en, 0);
		wait_high(1, ENDLY + 10);
		check(n >= ENDLY - 2, 1);
		check(prim_n, 0);
		wait_high(0, 50);
		shutdown = 1'b0;
		// Debug mode, then timing pin low alone
		sync_high = 1'b1;
		cap_low = 1'b1;
		cyc(3);
		check(debug, 1);
		f0 = fault_cnt;
		cyc(TO_CYC + 100);
		check({fault_cnt == f0, prim_n}, 3);
		sync_high = 1'b0;
		cyc(3);
		check({debug, prim_n}, 0);
		cap_low = 1'b0;
		wait_high(0, 30);
		// Larger timing cap lengthens the first-kick timeout
		cap_pf = 10'h00A;
		stat = wdt_pkg::supply_status_t'(GOOD ^ 7'h40);
		cyc(3);
		stat = GOOD;
		wait_high(0, 30);
		wait_fault(T2_CYC - 2 * TICK, T2_CYC + 3 * TICK, 3'h1);
		wait_high(0, 30);
		finish_test;
	end
endmodule
